// file: include/flash_xip_pkg.sv
// Notes on behaviour
// R1: dual read takes address two bits per clock
// R2: mode byte upper nibble steers next read
// R3: host floats lines before first data clock
// R4: mode bits 10 make dual read skip instruction
// R5: other mode bits restore normal instruction decode
// R6: mode reset command leaves continuous mode
// R7: variable latency sets mode plus dummy count
// R8: legacy dual latency is four mode cycles
// R9: quad read moves address, mode and data on four lines
// R10: quad read and wrap need quad enable
// R11: mode bits 10 make quad read skip instruction
// R12: legacy quad latency is two plus four
// R13: host may float low mode nibble
// R14: wrapped quad read cycles within aligned section
// R15: wrap command is instruction, dummies, wrap byte
// R16: wrap byte bits six to four stored
// R17: stored wrap setting governs later quad reads
// R18: wrap disabled after power-on and by setting
// R19: host clears wrap after its own reset
// R20: software reset reloads volatile defaults
// R21: deep power-down blocks software reset
// R22: reset needs enable, reset, then hold time
// R23: other command after enable cancels arming
// R24: all-ones mode byte ends continuous mode
// R25: data msb first, falling edges, address increments
package flash_xip_pkg;
	localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
	localparam logic [7:0] CMD_QUAD_IO_READ = 8'hEB;
	localparam logic [7:0] CMD_SET_WRAP     = 8'h77;
	localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
	localparam logic [7:0] CMD_RESET        = 8'h99;
	localparam int         QE_BIT           = 1;
	localparam logic [1:0] CONT_KEEP        = 2'h2;
	localparam logic [5:0] SYNC_RESET       = 6'h20; // cs high, sck low: no false edge after reset
	localparam logic [2:0] WRAP_DEFAULT     = 3'h7;
	localparam logic [4:0] CMD_CYC          = 5'h08;
	localparam logic [4:0] DUAL_ADDR_CYC    = 5'h0C;
	localparam logic [4:0] QUAD_ADDR_CYC    = 5'h06;
	localparam logic [4:0] DUAL_MODE_CYC    = 5'h04;
	localparam logic [4:0] QUAD_MODE_CYC    = 5'h02;
	localparam logic [4:0] DUAL_DUMMY_CYC   = 5'h00;
	localparam logic [4:0] QUAD_DUMMY_CYC   = 5'h04;
	localparam logic [4:0] WRAP_DUMMY_CYC   = 5'h06;
	localparam logic [4:0] WRAP_BITS_CYC    = 5'h02;
	localparam logic [3:0] OE_DUAL          = 4'h3;
	localparam logic [3:0] OE_QUAD          = 4'hF;
	localparam logic [5:0] WRAP_MASK [0:3]  = '{6'h07, 6'h0F, 6'h1F, 6'h3F};
	localparam int         ARRAY_WORDS      = 256;
	localparam int         CLK_MHZ          = 10;
	localparam int         RESET_SELECT_HOLD_NS = 100;
	localparam int         HOLD_CALC = (RESET_SELECT_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] RESET_HOLD_CYC   = 8'((HOLD_CALC < 1) ? 1 : HOLD_CALC);

	typedef enum logic [3:0] {
		S_IDLE, S_CMD, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_WRAP_DUMMY, S_WRAP_BITS, S_IGNORE
	} state_type;
endpackage : flash_xip_pkg

// file: include/xip_array_if.sv
`timescale 1ns/100ps
interface xip_array_if;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	modport ctrl  (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : xip_array_if

// file: core/xip_array.sv
`timescale 1ns/100ps
module xip_array
	import flash_xip_pkg::*;
(
	input wire logic   clk,
	input wire logic   nrst,
	xip_array_if.store port
);
	logic [7:0] mem_q [ARRAY_WORDS];

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port.rd_data <= '0;
		end else begin
			port.rd_data <= mem_q[port.rd_addr];
		end
	end
endmodule : xip_array

// file: core/xip_read_ctrl.sv
`timescale 1ns/100ps
module xip_read_ctrl
	import flash_xip_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       bidir_line_0_in,
	input  wire logic       bidir_line_1_in,
	input  wire logic       bidir_line_2_in,
	input  wire logic       bidir_line_3_in,
	output logic            bidir_line_0_out,
	output logic            bidir_line_1_out,
	output logic            bidir_line_2_out,
	output logic            bidir_line_3_out,
	output logic            bidir_line_0_oe,
	output logic            bidir_line_1_oe,
	output logic            bidir_line_2_oe,
	output logic            bidir_line_3_oe,
	input  wire logic [7:0] status_reg_two,
	input  wire logic       var_latency_en,
	input  wire logic [3:0] latency_ctrl,
	input  wire logic       in_deep_powerdown,
	input  wire logic       preload_en,
	input  wire logic [7:0] preload_addr,
	input  wire logic [7:0] preload_data,
	output logic [2:0]      wrap_setting,
	output logic            continuous_mode,
	output logic            soft_reset_pulse
);
	xip_array_if arr ();

	logic [5:0]  sync1_q;
	logic [5:0]  sync2_q;
	logic        sck_d_q;
	logic        cs_d_q;
	state_type   state_q;
	state_type   state_d;
	logic [4:0]  cnt_q;
	logic [31:0] shift_q;
	logic [31:0] shift_d;
	logic        quad_q;
	logic        quad_d;
	logic        cont_q;
	logic        cont_quad_q;
	logic [23:0] addr_q;
	logic [2:0]  wrap_q;
	logic [1:0]  idx_q;
	logic [3:0]  out_q;
	logic [3:0]  oe_q;
	logic        armed_q;
	logic        pend_q;
	logic [7:0]  hold_q;
	logic        rst_pulse_q;

	// two-stage synchronisers, then a third stage for edge finding
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= SYNC_RESET;
			sync2_q <= SYNC_RESET;
			sck_d_q <= 1'b0;
			cs_d_q  <= 1'b1;
		end else begin
			sync1_q <= {cs_n, sck, bidir_line_3_in, bidir_line_2_in, bidir_line_1_in,
				bidir_line_0_in};
			sync2_q <= sync1_q;
			sck_d_q <= sync2_q[4];
			cs_d_q  <= sync2_q[5];
		end
	end

	wire       cs_s     = sync2_q[5];
	wire       sck_s    = sync2_q[4];
	wire [3:0] in4      = sync2_q[3:0];
	wire       sck_rise = sck_s & ~sck_d_q;
	wire       sck_fall = ~sck_s & sck_d_q;
	wire       cs_fall  = ~cs_s & cs_d_q;
	wire       cs_rise  = cs_s & ~cs_d_q;

	// phase lengths and latency
	wire [4:0] mode_len  = quad_q ? QUAD_MODE_CYC : DUAL_MODE_CYC;
	wire [4:0] lat_total = var_latency_en ? {1'b0, latency_ctrl} :        // [R7]
		(quad_q ? QUAD_MODE_CYC + QUAD_DUMMY_CYC : DUAL_MODE_CYC + DUAL_DUMMY_CYC); // [R8] [R12]
	wire [4:0] dummy_len = (lat_total > mode_len) ? lat_total - mode_len : 5'h00;
	wire [4:0] phase_len =
		(state_q == S_CMD)        ? CMD_CYC :
		(state_q == S_ADDR)       ? (quad_q ? QUAD_ADDR_CYC : DUAL_ADDR_CYC) : // [R1] [R9]
		(state_q == S_MODE)       ? mode_len :
		(state_q == S_DUMMY)      ? dummy_len :
		(state_q == S_WRAP_DUMMY) ? WRAP_DUMMY_CYC : WRAP_BITS_CYC;          // [R15]
	wire       phase_end = sck_rise && (cnt_q == phase_len - 5'h01);

	// serial shifter: one line for the instruction, else two or four
	wire wide4 = quad_q || (state_q == S_WRAP_DUMMY) || (state_q == S_WRAP_BITS);
	assign shift_d = (state_q == S_CMD) ? {shift_q[30:0], in4[0]} :
		wide4 ? {shift_q[27:0], in4} : {shift_q[29:0], in4[1:0]};            // [R1] [R9]

	wire [7:0] cmd       = shift_d[7:0];
	wire       qe        = status_reg_two[QE_BIT];
	wire       is_dual   = cmd == CMD_DUAL_IO_READ;
	wire       is_quad   = cmd == CMD_QUAD_IO_READ;
	wire       is_wrap   = cmd == CMD_SET_WRAP;
	wire       is_rst_en = cmd == CMD_RESET_ENABLE;
	wire       is_rst    = cmd == CMD_RESET;
	wire       cmd_end   = (state_q == S_CMD) && phase_end;
	wire       mode_end  = (state_q == S_MODE) && phase_end;
	wire       wrap_end  = (state_q == S_WRAP_BITS) && phase_end;
	wire       cont_go   = (state_q == S_IDLE) && cs_fall && cont_q;

	always_comb begin
		state_d = state_q;
		if (cs_rise) begin
			state_d = S_IDLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (cs_fall) begin
						state_d = cont_q ? S_ADDR : S_CMD;                // [R4] [R5] [R11]
					end
				end
				S_CMD: begin
					if (phase_end) begin
						if (is_dual || (is_quad && qe)) begin            // [R10]
							state_d = S_ADDR;
						end else if (is_wrap && qe) begin                // [R10]
							state_d = S_WRAP_DUMMY;
						end else begin
							state_d = S_IGNORE;
						end
					end
				end
				S_ADDR: begin
					if (phase_end) begin
						state_d = S_MODE;
					end
				end
				S_MODE: begin
					if (phase_end) begin
						state_d = (dummy_len == 5'h00) ? S_DATA : S_DUMMY;  // [R8] [R12]
					end
				end
				S_DUMMY: begin
					if (phase_end) begin
						state_d = S_DATA;
					end
				end
				S_WRAP_DUMMY: begin
					if (phase_end) begin
						state_d = S_WRAP_BITS;
					end
				end
				S_WRAP_BITS: begin
					if (phase_end) begin
						state_d = S_IGNORE;
					end
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
	end

	assign quad_d = cont_go ? cont_quad_q : cmd_end ? is_quad : quad_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			cnt_q   <= '0;
			shift_q <= '0;
			quad_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= (state_d != state_q) ? 5'h00 : cnt_q + {4'h0, sck_rise};
			shift_q <= sck_rise ? shift_d : shift_q;
			quad_q  <= quad_d;
		end
	end

	// continuous mode; an all-ones mode byte reads as bits 11 and exits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cont_q      <= 1'b0;
			cont_quad_q <= 1'b0;
		end else if (rst_pulse_q) begin
			cont_q      <= 1'b0;                                             // [R20]
		end else if (mode_end) begin
			cont_q      <= shift_d[5:4] == CONT_KEEP;                        // [R2] [R5] [R6] [R24]
			cont_quad_q <= quad_q;                                           // [R4] [R11]
		end
	end

	// wrap setting, disabled after reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrap_q <= WRAP_DEFAULT;                                          // [R18]
		end else if (rst_pulse_q) begin
			wrap_q <= WRAP_DEFAULT;                                          // [R20]
		end else if (wrap_end) begin
			wrap_q <= shift_d[6:4];                                          // [R15] [R16] [R18]
		end
	end

	// read address: linear, or wrapped within the aligned section
	wire        wrap_en   = quad_q && !wrap_q[0];                          // [R17]
	wire [23:0] wrap_mask = {18'h0, WRAP_MASK[wrap_q[2:1]]};
	wire [23:0] addr_inc  = addr_q + 24'h1;
	wire [23:0] next_addr = wrap_en ? ((addr_q & ~wrap_mask) | (addr_inc & wrap_mask)) // [R14]
		: addr_inc;                                                        // [R25]
	wire        data_fall = (state_q == S_DATA) && sck_fall;
	wire        idx_last  = quad_q ? (idx_q == 2'h1) : (idx_q == 2'h3);
	wire [7:0]  rd        = arr.rd_data;
	wire [1:0]  dual_pair = (idx_q == 2'h0) ? rd[7:6] : (idx_q == 2'h1) ? rd[5:4] :
		(idx_q == 2'h2) ? rd[3:2] : rd[1:0];
	wire [3:0]  slice4    = quad_q ? (idx_q[0] ? rd[3:0] : rd[7:4]) : {2'b00, dual_pair};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= '0;
		end else if ((state_q == S_ADDR) && phase_end) begin
			addr_q <= shift_d[23:0];                                         // [R1] [R9]
		end else if (data_fall && idx_last) begin
			addr_q <= next_addr;                                             // [R14] [R25]
		end
	end

	// data out on falling edges, msb group first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_q <= '0;
			oe_q  <= '0;
			idx_q <= '0;
		end else if (cs_rise) begin
			oe_q  <= '0;
			idx_q <= '0;
		end else if (data_fall) begin
			out_q <= slice4;                                                 // [R25]
			oe_q  <= quad_q ? OE_QUAD : OE_DUAL;
			idx_q <= idx_last ? 2'h0 : idx_q + 2'h1;
		end
	end

	// software reset: enable, reset, hold, then chip select rise
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed_q     <= 1'b0;
			pend_q      <= 1'b0;
			hold_q      <= '0;
			rst_pulse_q <= 1'b0;
		end else begin
			rst_pulse_q <= cs_rise && pend_q && (hold_q >= RESET_HOLD_CYC)  // [R22]
				&& !in_deep_powerdown;                                     // [R21]
			if (cmd_end) begin
				armed_q <= is_rst_en && !in_deep_powerdown;                  // [R21] [R23]
				pend_q  <= is_rst && armed_q && !in_deep_powerdown;          // [R22]
				hold_q  <= '0;
			end else begin
				if (cont_go || rst_pulse_q) begin
					armed_q <= 1'b0;                                         // [R23]
				end
				if (cs_rise) begin
					pend_q <= 1'b0;
				end
				if (pend_q && (hold_q < RESET_HOLD_CYC)) begin
					hold_q <= hold_q + 8'h01;
				end
			end
		end
	end

	assign arr.rd_addr = addr_q[7:0];
	assign arr.wr_en   = preload_en;
	assign arr.wr_addr = preload_addr;
	assign arr.wr_data = preload_data;

	xip_array u_array (
		.clk  (clk),
		.nrst (nrst),
		.port (arr.store)
	);

	assign bidir_line_0_out = out_q[0];
	assign bidir_line_1_out = out_q[1];
	assign bidir_line_2_out = out_q[2];
	assign bidir_line_3_out = out_q[3];
	assign bidir_line_0_oe  = oe_q[0];
	assign bidir_line_1_oe  = oe_q[1];
	assign bidir_line_2_oe  = oe_q[2];
	assign bidir_line_3_oe  = oe_q[3];
	assign wrap_setting     = wrap_q;
	assign continuous_mode  = cont_q;
	assign soft_reset_pulse = rst_pulse_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_qe_gates_quad: assert property ((cmd_end && (is_quad || is_wrap) && !qe && !cs_rise) // [R10]
		|=> state_q == S_IGNORE) else $error("quad command taken without quad enable");
	a_cont_skips_cmd: assert property (cont_go |=> (state_q == S_ADDR) // [R4] [R11]
		&& (quad_q == $past(cont_quad_q))) else $error("continuous read did not skip instruction");
	a_normal_needs_cmd: assert property (((state_q == S_IDLE) && cs_fall && !cont_q) // [R5]
		|=> state_q == S_CMD) else $error("instruction phase missing");
	a_mode_sets_cont: assert property (mode_end |=> // [R2] [R24]
		cont_q == ($past(shift_d[5:4]) == CONT_KEEP)) else $error("mode byte misread");
	a_dual_legacy_lat: assert property ((mode_end && !quad_q && !var_latency_en && !cs_rise) // [R8]
		|=> state_q == S_DATA) else $error("dual legacy latency wrong");
	a_quad_legacy_lat: assert property ((mode_end && quad_q && !var_latency_en && !cs_rise) // [R12]
		|=> (state_q == S_DUMMY) && (dummy_len == QUAD_DUMMY_CYC))
		else $error("quad legacy latency wrong");
	a_wrap_load: assert property ((wrap_end && !cs_rise) |=> // [R16]
		wrap_q == $past(shift_d[6:4])) else $error("wrap setting not loaded");
	a_wrap_in_section: assert property ((data_fall && idx_last && wrap_en && !cs_rise) // [R14]
		|=> (addr_q & ~wrap_mask) == $past(addr_q & ~wrap_mask)) else $error("wrap left section");
	a_reset_restores: assert property (soft_reset_pulse |=> // [R20]
		(wrap_q == WRAP_DEFAULT) && !cont_q && !armed_q) else $error("reset left state");
	a_powerdown_no_reset: assert property ($past(in_deep_powerdown) |-> // [R21]
		!soft_reset_pulse) else $error("reset accepted in power-down");
	a_arm_cancel: assert property ((cmd_end && !is_rst_en) |=> !armed_q) // [R23]
		else $error("reset arming not cancelled");
	a_hold_short: assert property ((cs_rise && pend_q && (hold_q < RESET_HOLD_CYC)) // [R22]
		|=> !soft_reset_pulse) else $error("reset without hold time");

	c_dual_data: cover property ((state_q == S_DATA) && data_fall && !quad_q);
	c_quad_wrap: cover property (data_fall && idx_last && wrap_en);
	c_soft_reset: cover property (soft_reset_pulse);
	c_cont_entry: cover property (cont_go);
endmodule : xip_read_ctrl

// file: bench/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model
(
	input  wire logic       clk,
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe,
	output logic            sck,
	output logic            cs_n,
	output logic [3:0]      line_in
);
	logic [3:0] hval;
	logic [3:0] hoe;
	logic [3:0] flt_q;
	logic [3:0] oe_seen;
	logic [3:0] grp;
	logic       clash;
	logic [7:0] rx_q [$];

	// undriven lines toggle every cycle
	assign line_in = (dev_oe & dev_out) | (~dev_oe & hoe & hval) | (~dev_oe & ~hoe & flt_q);

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		hval = 4'h0;
		hoe = 4'h0;
		flt_q = 4'h5;
		oe_seen = 4'h0;
		clash = 1'b0;
	end

	always @(posedge clk) begin
		flt_q <= ~flt_q;
		if (!cs_n)
			oe_seen <= oe_seen | dev_oe;
		if ((dev_oe & hoe) != 4'h0)
			clash <= 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// lines set in low half, sampled late in high half
	task automatic cyc(input logic [3:0] v, input logic [3:0] drv);
		sck <= 1'b0;
		hval <= v;
		hoe <= drv;
		tick(4);
		sck <= 1'b1;
		tick(3);
		grp = line_in;
		tick(1);
	endtask : cyc

	task automatic frame(input logic [7:0] cmd, input bit with_cmd, input int w,
			input logic [31:0] hdr, input int hcyc, input int nflt, input int dum, input int nb);
		logic [7:0] b;
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		oe_seen <= 4'h0;
		cs_n <= 1'b0;
		tick(4);
		for (int i = 7; i >= 0 && with_cmd; i--)
			cyc({3'h0, cmd[i]}, 4'h1);
		for (int i = 0; i < hcyc; i++)
			cyc(4'(hdr >> (32 - w * (i + 1))) & m, (i < hcyc - nflt) ? m : 4'h0);
		repeat (dum)
			cyc(4'h0, 4'h0);
		rx_q.delete();
		for (int n = 0; n < nb; n++) begin
			for (int k = 0; k < 8 / w; k++) begin
				cyc(4'h0, 4'h0);
				b = 8'((b << w) | grp & m);
			end
			rx_q.push_back(b);
		end
		sck <= 1'b0;
		hoe <= 4'h0;
		tick(4);
		cs_n <= 1'b1;
		tick(8);
	endtask : frame
endmodule : spi_host_model

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
	import flash_xip_pkg::*;
	logic       clk, nrst, sck, cs_n, var_latency_en, in_deep_powerdown, preload_en;
	logic       continuous_mode, soft_reset_pulse;
	logic [3:0] line_in, latency_ctrl;
	wire  [3:0] dev_out, dev_oe;
	logic [7:0] status_reg_two, preload_addr, preload_data;
	logic [2:0] wrap_setting;
	int         miscompares, n_compared, n_pulses, seed, wrap_m, cont_m;
	int         mem [256];
	int         modes [7] = '{2, 2, 0, 2, 1, 3, 2};

	xip_read_ctrl u_xip_read_ctrl (.clk, .nrst, .sck, .cs_n,
		.bidir_line_0_in(line_in[0]), .bidir_line_1_in(line_in[1]),
		.bidir_line_2_in(line_in[2]), .bidir_line_3_in(line_in[3]),
		.bidir_line_0_out(dev_out[0]), .bidir_line_1_out(dev_out[1]),
		.bidir_line_2_out(dev_out[2]), .bidir_line_3_out(dev_out[3]),
		.bidir_line_0_oe(dev_oe[0]), .bidir_line_1_oe(dev_oe[1]),
		.bidir_line_2_oe(dev_oe[2]), .bidir_line_3_oe(dev_oe[3]),
		.status_reg_two, .var_latency_en, .latency_ctrl, .in_deep_powerdown,
		.preload_en, .preload_addr, .preload_data, .wrap_setting, .continuous_mode,
		.soft_reset_pulse);
	spi_host_model u_spi_host_model (.clk, .dev_out, .dev_oe, .sck, .cs_n, .line_in);

	always #50 clk = ~clk;

	always @(posedge clk)
		if (soft_reset_pulse === 1'b1)
			n_pulses++;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict;
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic rd(input bit q, input logic [23:0] a, input logic [7:0] md, input int nb);
		int mc;
		int dum;
		int sz;
		int idx;
		mc = q ? 2 : 4;
		dum = var_latency_en ? ((latency_ctrl > mc) ? latency_ctrl - mc : 0) : (q ? 4 : 0);
		u_spi_host_model.frame(q ? CMD_QUAD_IO_READ : CMD_DUAL_IO_READ, cont_m == 0,
			q ? 4 : 2, {a, md}, q ? 8 : 16, q, dum, nb);
		sz = 8 << wrap_m[2:1];
		for (int i = 0; i < nb; i++) begin
			idx = (q && !wrap_m[0]) ? (a & ~(sz - 1) | (a + i) & (sz - 1)) : a + i;
			check("read data", u_spi_host_model.rx_q[i], mem[idx & 255]);
		end
		check("drive enables", u_spi_host_model.oe_seen, q ? OE_QUAD : OE_DUAL);
		cont_m = md[5:4] == 2'h2;
		check("continuous mode", continuous_mode, cont_m);
	endtask : rd

	task automatic set_wrap(input logic [7:0] wb);
		u_spi_host_model.frame(CMD_SET_WRAP, 1'b1, 4, {24'($random(seed)), wb}, 8, 0, 0, 0);
		if (status_reg_two[QE_BIT] === 1'b1)
			wrap_m = wb[6:4];
		@(posedge clk);
		check("wrap setting", wrap_setting, wrap_m);
	endtask : set_wrap

	task automatic sw_reset(input logic [7:0] mid, input int pulses);
		int p0;
		p0 = n_pulses;
		u_spi_host_model.frame(CMD_RESET_ENABLE, 1'b1, 1, 32'h0, 0, 0, 0, 0);
		if (mid != 8'h00)
			u_spi_host_model.frame(mid, 1'b1, 1, 32'h0, 0, 0, 0, 0);
		u_spi_host_model.frame(CMD_RESET, 1'b1, 1, 32'h0, 0, 0, 0, 0);
		if (pulses > 0)
			wrap_m = 7;
		check("reset pulses", n_pulses - p0, pulses);
		check("wrap setting", wrap_setting, wrap_m);
	endtask : sw_reset

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		var_latency_en = 1'b0;
		latency_ctrl = 4'h0;
		in_deep_powerdown = 1'b0;
		preload_en = 1'b0;
		preload_addr = 8'h00;
		preload_data = 8'h00;
		status_reg_two = 8'h00;
		seed = 32'hAAE96227;
		wrap_m = 7;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		check("wrap after reset", wrap_setting, 3'h7);
		check("idle enables", dev_oe, 4'h0);
		for (int i = 0; i < 256; i++) begin
			mem[i] = $random(seed) & 255;
			preload_en <= 1'b1;
			preload_addr <= 8'(i);
			preload_data <= 8'(mem[i]);
			@(posedge clk);
		end
		preload_en <= 1'b0;
		@(posedge clk);
		u_spi_host_model.frame(CMD_QUAD_IO_READ, 1'b1, 4, 32'h20, 8, 0, 4, 2);
		check("refused enables", u_spi_host_model.oe_seen, 4'h0);
		check("continuous mode", continuous_mode, 1'b0);
		set_wrap(8'h00);
		for (int v = 0; v < 4; v++) begin
			status_reg_two <= 8'($random(seed)) | 8'h02;
			var_latency_en <= v[0];
			latency_ctrl <= 4'h5 + 4'(v);
			@(posedge clk);
			foreach (modes[j])
				rd(v[1], 24'($random(seed)), {2'(j), 2'(modes[j]), 4'($random(seed))}, 3);
			u_spi_host_model.frame(8'h00, 1'b0, v[1] ? 4 : 2, 32'hFFFFFFFF, v[1] ? 8 : 16, 0, 0, 0);
			cont_m = 0;
			check("continuous mode", continuous_mode, 1'b0);
			rd(v[1], 24'($random(seed)), 8'h00, 2);
		end
		for (int ls = 0; ls < 4; ls++) begin
			set_wrap({1'b1, 2'(ls), 1'b0, 4'hA});
			rd(1'b1, 24'($random(seed)), 8'h00, (8 << ls) + 3);
			rd(1'b0, 24'($random(seed)), 8'h00, 12);
		end
		set_wrap(8'h5F);
		rd(1'b1, 24'($random(seed)), 8'h00, 20);
		set_wrap(8'h60);
		in_deep_powerdown <= 1'b1;
		@(posedge clk);
		sw_reset(8'h00, 0);
		in_deep_powerdown <= 1'b0;
		@(posedge clk);
		sw_reset(8'h05, 0);
		sw_reset(8'h00, 1);
		rd(1'b1, 24'($random(seed)), 8'h00, 70);
		check("host contention", u_spi_host_model.clash, 1'b0);
		print_verdict();
	end
endmodule : tb
